// ==== rtl/hcw_assembler.sv ====
// Purpose: assemble and shift out hopping and seed code words
// Assumes: cipher is external; counter storage is external
// Notes:   one code word per request, lsb first on tx_data
`timescale 1ns/1ps

module hcw_assembler (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // configuration sets
  input  wire hcw_pkg::hcw_cfg_t cfg_first,
  input  wire hcw_pkg::hcw_cfg_t cfg_second,
  input  wire hcw_pkg::hcw_dev_t dev_opts,
  input  wire logic              config_select,
  // buttons and press events
  input  wire logic [5:0]        button_inputs,
  input  wire logic              press_start,
  // code word request and word counting
  input  wire logic              word_request,
  input  wire logic              first_preamble,
  input  wire logic [3:0]        words_sent,
  // cipher handshake
  output logic                   crypt_start,
  output logic [31:0]            crypt_plain,
  output logic                   crypt_first_key,
  input  wire logic              crypt_done,
  input  wire logic [31:0]       crypt_result,
  // low voltage detector
  input  wire logic              detector_low,
  output logic                   detector_trip_high,
  output logic                   detector_latched,
  output logic                   preamble_stretch,
  // counter update toward storage
  output logic                   counter_advance,
  output logic                   counter_word_seed,
  // serial output
  output logic                   tx_data,
  output logic                   tx_valid,
  output logic                   tx_last,
  output logic                   low_voltage_flag
);

  // ****************************************************************
  // configuration selection
  // ****************************************************************
  hcw_pkg::hcw_cfg_t cfg;
  logic [3:0]  func_code;
  logic [3:0]  btn_low;
  logic        seed_ok;
  logic        want_seed;
  logic        limit_seen;
  logic [31:0] hop_plain;
  logic [31:0] fixed_part;
  logic [1:0]  mtx_cnt;

  // live set follows select pin; device options shared
  assign cfg = config_select ? cfg_second : cfg_first;
  assign btn_low = button_inputs[3:0];

  // button to function mapping, patterns ORed
  always_comb begin
    func_code = 4'h0;
    if (button_inputs[0]) func_code = func_code | 4'h2;
    if (button_inputs[1]) func_code = func_code | 4'h4;
    if (button_inputs[2]) func_code = func_code | 4'h8;
    if (button_inputs[3]) func_code = func_code | 4'h1;
    if (button_inputs[4]) func_code = func_code | 4'he;
    if (button_inputs[5]) func_code = func_code | 4'hd;
  end

  // plaintext for the hopping part
  always_comb begin
    if (dev_opts.counter_width_select) begin
      hop_plain = {func_code, cfg.discrimination_value[7:0],
                   cfg.sync_counter};
    end else begin
      hop_plain = {func_code, cfg.second_overflow_bit,
                   cfg.first_overflow_bit,
                   cfg.discrimination_value,
                   cfg.sync_counter[15:0]};
    end
  end

  // fixed part: short serial plus function, or whole serial
  assign fixed_part = cfg.extended_serial_enable ? cfg.serial_number
    : {func_code, cfg.serial_number[27:0]};

  // seed eligibility; counter past limit keeps seeds off
  always_comb begin
    seed_ok = (cfg.seed_button_field != 4'h0) &&
              (btn_low == cfg.seed_button_field);
    if (cfg.limited_seed_enable &&
        (cfg.sync_counter > hcw_pkg::SEED_LIMIT || limit_seen))
      seed_ok = 1'b0;
  end

  assign mtx_cnt = cfg.minimum_word_count;

  // ****************************************************************
  // seed delay and production timing
  // ****************************************************************
  logic [31:0] press_timer_q;
  logic [31:0] delay_target;
  logic        delay_done;
  logic        prod_active;
  logic [3:0]  mtx_words;
  logic [1:0]  seed_limit_q;

  always_comb begin
    case (cfg.seed_delay_select)
      2'h1:    delay_target = 32'(hcw_pkg::SEED_DLY_CYC1);
      2'h2:    delay_target = 32'(hcw_pkg::SEED_DLY_CYC2);
      2'h3:    delay_target = 32'(hcw_pkg::SEED_DLY_CYC3);
      default: delay_target = 32'h0;
    endcase
  end

  assign delay_done = press_timer_q >= delay_target;
  assign mtx_words  = 4'h1 << mtx_cnt;

  // time since press start, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      press_timer_q <= 32'h0;
    end else if (press_start) begin
      press_timer_q <= 32'h0;
    end else if (press_timer_q != 32'hffffffff) begin
      press_timer_q <= press_timer_q + 32'h1;
    end
  end

  // one sticky flag per set: a rolled-over counter stays past 127,
  // and one set's counter never disables the other set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seed_limit_q <= 2'h0;
    end else begin
      if (cfg_first.sync_counter >= hcw_pkg::PROD_LIMIT)
        seed_limit_q[0] <= 1'b1;
      if (cfg_second.sync_counter >= hcw_pkg::PROD_LIMIT)
        seed_limit_q[1] <= 1'b1;
    end
  end

  assign limit_seen  = seed_limit_q[config_select];
  assign prod_active = cfg.seed_production_mode && !limit_seen &&
                       cfg.sync_counter < hcw_pkg::PROD_LIMIT;

  // seed choice: production after minimum words, otherwise after delay
  always_comb begin
    want_seed = 1'b0;
    if (seed_ok) begin
      if (prod_active)
        want_seed = words_sent >= mtx_words;
      else
        want_seed = delay_done;
    end
  end

  // ****************************************************************
  // low voltage detector
  // ****************************************************************
  logic low_voltage_flag_q;
  logic latch_q;
  logic stretch_q;
  logic [23:0] stretch_cnt_q;

  assign detector_trip_high = dev_opts.low_voltage_trip_select;
  assign detector_latched   = latch_q;
  assign low_voltage_flag   = low_voltage_flag_q;
  assign preamble_stretch   = stretch_q;

  // sample on first preamble pulse; latch holds the flag set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_voltage_flag_q  <= 1'b0;
      latch_q <= 1'b0;
    end else if (first_preamble) begin
      low_voltage_flag_q <= detector_low || latch_q;
      if (dev_opts.low_voltage_latch_enable && detector_low)
        latch_q <= 1'b1;
    end
  end

  // one 4 ms stretch when latch changes state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stretch_q     <= 1'b0;
      stretch_cnt_q <= 24'h0;
    end else if (first_preamble && dev_opts.low_voltage_latch_enable &&
                 detector_low && !latch_q) begin
      stretch_q     <= 1'b1;
      stretch_cnt_q <= 24'(hcw_pkg::STRETCH_CYC - 1);
    end else if (stretch_cnt_q != 24'h0) begin
      stretch_cnt_q <= stretch_cnt_q - 24'h1;
    end else begin
      stretch_q <= 1'b0;
    end
  end

  // ****************************************************************
  // queue counter
  // ****************************************************************
  logic [1:0] queue_q;
  logic [3:0] last_func_q;

  // saturating repeat count within two seconds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      queue_q     <= hcw_pkg::QUEUE_RST;
      last_func_q <= 4'h0;
    end else if (press_start) begin
      last_func_q <= func_code;
      if (cfg.queue_counter_enable && func_code == last_func_q &&
          press_timer_q < 32'(hcw_pkg::QUEUE_WIN_CYC)) begin
        if (queue_q != 2'h3)
          queue_q <= queue_q + 2'h1;
      end else begin
        queue_q <= hcw_pkg::QUEUE_RST;
      end
    end
  end

  // ****************************************************************
  // hopping code, held per press
  // ****************************************************************
  hcw_pkg::hcw_state_t state_q;
  logic [31:0] hop_q;
  logic        hop_valid_q;

  assign crypt_start     = (state_q == hcw_pkg::ST_CRYPT);
  assign crypt_plain     = hop_plain;
  assign crypt_first_key = !config_select;

  // result captured once per press, reused by repeats
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hop_q       <= 32'h0;
      hop_valid_q <= 1'b0;
    end else if (press_start) begin
      hop_valid_q <= 1'b0;
    end else if (state_q == hcw_pkg::ST_CRYPT && crypt_done) begin
      hop_q       <= crypt_result;
      hop_valid_q <= 1'b1;
    end
  end

  // ****************************************************************
  // word assembly and shifter
  // ****************************************************************
  logic [68:0] word_q;
  logic [6:0]  bit_cnt_q;
  logic [6:0]  word_len_q;
  logic [1:0]  crc_q;
  logic        seed_word_q;
  logic [64:0] body;
  logic        crc_in;

  // body: lsb first hopping then fixed, or seed then function
  always_comb begin
    if (want_seed)
      body = {low_voltage_flag_q, hcw_pkg::FUNC_SEED, cfg.seed_value};
    else
      body = {low_voltage_flag_q, fixed_part, hop_q};
  end

  assign crc_in = word_q[0];

  // word state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= hcw_pkg::ST_IDLE;
    end else begin
      case (state_q)
        hcw_pkg::ST_IDLE:
          if (word_request)
            state_q <= hop_valid_q ? hcw_pkg::ST_SHIFT
                                   : hcw_pkg::ST_CRYPT;
        hcw_pkg::ST_CRYPT:
          if (crypt_done) state_q <= hcw_pkg::ST_DONE;
        hcw_pkg::ST_DONE:
          state_q <= hcw_pkg::ST_SHIFT;
        hcw_pkg::ST_SHIFT:
          if (bit_cnt_q == word_len_q - 7'h1)
            state_q <= hcw_pkg::ST_IDLE;
        default:
          state_q <= hcw_pkg::ST_IDLE;
      endcase
    end
  end

  // load then shift lsb first; crc runs over first 65 bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_q      <= 69'h0;
      bit_cnt_q   <= 7'h0;
      word_len_q  <= 7'(hcw_pkg::LEN_BASE);
      crc_q       <= hcw_pkg::CRC_RST;
      seed_word_q <= 1'b0;
    end else if ((state_q == hcw_pkg::ST_IDLE && word_request &&
                  hop_valid_q) || state_q == hcw_pkg::ST_DONE) begin
      word_q      <= {queue_q, 2'h0, body};
      word_len_q  <= cfg.queue_counter_enable ? 7'(hcw_pkg::LEN_QUEUE)
                                              : 7'(hcw_pkg::LEN_BASE);
      bit_cnt_q   <= 7'h0;
      crc_q       <= hcw_pkg::CRC_RST;
      seed_word_q <= want_seed;
    end else if (state_q == hcw_pkg::ST_SHIFT) begin
      bit_cnt_q <= bit_cnt_q + 7'h1;
      word_q    <= {1'b0, word_q[68:1]};
      if (bit_cnt_q < 7'(hcw_pkg::CRC_SPAN))
        crc_q <= {crc_q[0] ^ crc_in, crc_q[0] ^ crc_in ^ crc_q[1]};
      // with the flag bit going out, the two empty slots get the crc
      if (bit_cnt_q == 7'(hcw_pkg::CRC_SPAN - 1))
        word_q <= {65'h0, word_q[4:3], crc_q[0] ^ crc_in,
                   crc_q[0] ^ crc_in ^ crc_q[1]};
    end
  end

  assign tx_valid = (state_q == hcw_pkg::ST_SHIFT);
  assign tx_last  = tx_valid && (bit_cnt_q == word_len_q - 7'h1);

  // data straight from the shifter lsb
  assign tx_data = word_q[0];

  // counter advance at end of word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_advance   <= 1'b0;
      counter_word_seed <= 1'b0;
    end else begin
      counter_advance <= tx_last && (!seed_word_q || prod_active ||
                         cfg.seed_delay_select != 2'h0);
      counter_word_seed <= seed_word_q;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_load;
    state_q == hcw_pkg::ST_DONE;
  endsequence

  AST_LEN_QUEUE: assert property (@(posedge clk) disable iff (!rst_n)
    s_load |=> word_len_q == (cfg.queue_counter_enable ? 7'd69 : 7'd67))
    else $error("word length wrong");
  AST_SEED_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.seed_button_field == 4'h0 |-> !want_seed)
    else $error("seed with zero field");
  AST_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.limited_seed_enable && cfg.sync_counter > 20'd127 |-> !seed_ok)
    else $error("seed past limit");
  AST_FIX: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.extended_serial_enable |-> fixed_part[31:28] == func_code)
    else $error("fixed function copy");
  AST_SEL: assert property (@(posedge clk) disable iff (!rst_n)
    config_select |-> !crypt_first_key &&
      crypt_plain[15:0] == cfg_second.sync_counter[15:0])
    else $error("wrong set");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    hop_valid_q && !press_start |=> $stable(hop_q))
    else $error("hop changed");
  AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    latch_q && first_preamble |=> low_voltage_flag_q)
    else $error("latched flag lost");
  AST_ADV: assert property (@(posedge clk) disable iff (!rst_n)
    tx_last && !seed_word_q |=> counter_advance)
    else $error("no advance");

endmodule

// ==== rtl/hcw_pkg.sv ====
// Purpose: shared constants and carriers for the code word assembler
// Assumes: one clock at 200 MHz, synchronous active-low reset
// Notes:   field positions follow the assembled word, lsb first
package hcw_pkg;

  // ****************************************************************
  // word layout
  // ****************************************************************
  localparam int HOP_W        = 32;
  localparam int FIX_W        = 32;
  localparam int SEED_W       = 60;
  localparam int FUNC_W       = 4;
  localparam int WORD_W       = 69;
  localparam int CRC_SPAN     = 65;
  localparam int LEN_BASE     = 67;
  localparam int LEN_QUEUE    = 69;
  localparam int SER_SHORT_W  = 28;
  localparam int DISCRIMINATION_VALUE_LONG_W  = 10;
  localparam int DISCRIMINATION_VALUE_SHORT_W = 8;
  localparam int POS_LOW_VOLTAGE_FLAG     = 64;
  localparam int POS_CRC      = 65;
  localparam int POS_QUEUE    = 67;
  localparam logic [3:0]  FUNC_SEED   = 4'hf;
  localparam logic [19:0] SEED_LIMIT  = 20'h0007f;
  localparam logic [19:0] PROD_LIMIT  = 20'h00080;
  localparam logic [15:0] CNT16_MAX   = 16'hffff;
  localparam logic [19:0] CNT20_MAX   = 20'hfffff;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int  CLK_MHZ        = 200;
  localparam int  QUEUE_WIN_MS   = 2000;
  localparam int  STRETCH_MS     = 4;
  localparam int  SEED_DLY_MS_1  = 800;
  localparam int  SEED_DLY_MS_2  = 1600;
  localparam int  SEED_DLY_MS_3  = 3200;
  localparam longint QUEUE_WIN_CYC = longint'(QUEUE_WIN_MS) * CLK_MHZ * 1000;
  localparam longint STRETCH_CYC   = longint'(STRETCH_MS) * CLK_MHZ * 1000;
  localparam longint SEED_DLY_CYC1 = longint'(SEED_DLY_MS_1) * CLK_MHZ * 1000;
  localparam longint SEED_DLY_CYC2 = longint'(SEED_DLY_MS_2) * CLK_MHZ * 1000;
  localparam longint SEED_DLY_CYC3 = longint'(SEED_DLY_MS_3) * CLK_MHZ * 1000;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [1:0] QUEUE_RST = 2'h0;
  localparam logic [1:0] CRC_RST   = 2'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // per-encoder configuration set
  typedef struct packed {
    logic [31:0] serial_number;
    logic [9:0]  discrimination_value;
    logic [59:0] seed_value;
    logic [19:0] sync_counter;
    logic        first_overflow_bit;
    logic        second_overflow_bit;
    logic        extended_serial_enable;
    logic        queue_counter_enable;
    logic [3:0]  seed_button_field;
    logic        limited_seed_enable;
    logic [1:0]  seed_delay_select;
    logic        seed_production_mode;
    logic [1:0]  minimum_word_count;
  } hcw_cfg_t;

  // options common to both encoders
  typedef struct packed {
    logic counter_width_select;
    logic low_voltage_latch_enable;
    logic low_voltage_trip_select;
  } hcw_dev_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CRYPT = 2'b01,
    ST_DONE  = 2'b11,
    ST_SHIFT = 2'b10
  } hcw_state_t;

endpackage

// ==== testbench/hcw_assembler_tb_top.sv ====
// Purpose: self-checking bench for the code word assembler
// Assumes: inputs driven on the falling edge, words captured by far model
// Notes:   long timers untested; seed delay stays at zero
`timescale 1ns/1ps

module hcw_assembler_tb_top;
  localparam logic [31:0] KEY_A = 32'h3c5a96e1;
  localparam logic [31:0] KEY_B = 32'h0f1e2d3c;
  logic              clk;
  logic              rst_n;
  hcw_pkg::hcw_cfg_t cfg_first;
  hcw_pkg::hcw_cfg_t cfg_second;
  hcw_pkg::hcw_dev_t dev_opts;
  logic              config_select;
  logic [5:0]        button_inputs;
  logic              press_start;
  logic              word_request;
  logic              first_preamble;
  logic [3:0]        words_sent;
  logic              detector_low;
  logic              crypt_start;
  logic [31:0]       crypt_plain;
  logic              crypt_first_key;
  logic              crypt_done;
  logic [31:0]       crypt_result;
  logic              detector_trip_high;
  logic              detector_latched;
  logic              counter_advance;
  logic              counter_word_seed;
  logic              preamble_stretch;
  logic              tx_data;
  logic              tx_valid;
  logic              tx_last;
  logic              low_voltage_flag;
  int                num_errors = 0;
  int                num_checks = 0;
  int                c0;

  hcw_assembler dut_u (
    .clk(clk), .rst_n(rst_n), .cfg_first(cfg_first),
    .cfg_second(cfg_second), .dev_opts(dev_opts),
    .config_select(config_select), .button_inputs(button_inputs),
    .press_start(press_start), .word_request(word_request),
    .first_preamble(first_preamble), .words_sent(words_sent),
    .crypt_start(crypt_start), .crypt_plain(crypt_plain),
    .crypt_first_key(crypt_first_key), .crypt_done(crypt_done),
    .crypt_result(crypt_result), .detector_low(detector_low),
    .detector_trip_high(detector_trip_high),
    .detector_latched(detector_latched),
    .preamble_stretch(preamble_stretch),
    .counter_advance(counter_advance),
    .counter_word_seed(counter_word_seed),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .low_voltage_flag(low_voltage_flag));

  hcw_far_model #(.KEY_A(KEY_A), .KEY_B(KEY_B)) fm_u (
    .clk(clk), .crypt_start(crypt_start), .crypt_plain(crypt_plain),
    .crypt_first_key(crypt_first_key), .crypt_done(crypt_done),
    .crypt_result(crypt_result), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .counter_advance(counter_advance));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string name, logic [68:0] exp, logic [68:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // expected word built from the option set, independent of the design
  function automatic logic [68:0] exp_word(logic [5:0] b, logic v,
      logic [1:0] q, logic sd);
    hcw_pkg::hcw_cfg_t c;
    logic [3:0]  f;
    logic [31:0] p;
    logic [31:0] fx;
    logic [68:0] w;
    logic [1:0]  r;
    c = config_select ? cfg_second : cfg_first;
    f = {b[2] | b[4] | b[5], b[1] | b[4] | b[5], b[0] | b[4], b[3] | b[5]};
    if (dev_opts.counter_width_select)
      p = {f, c.discrimination_value[7:0], c.sync_counter};
    else
      p = {f, c.second_overflow_bit, c.first_overflow_bit,
           c.discrimination_value, c.sync_counter[15:0]};
    fx = c.extended_serial_enable ? c.serial_number
                                  : {f, c.serial_number[27:0]};
    if (sd) w = {q, 2'h0, v, hcw_pkg::FUNC_SEED, c.seed_value};
    else w = {q, 2'h0, v, fx, p ^ (config_select ? KEY_B : KEY_A)};
    r = 2'h0;
    for (int n = 0; n < hcw_pkg::CRC_SPAN; n++)
      r = {r[0] ^ w[n], r[0] ^ w[n] ^ r[1]};
    w[66:65] = r;
    if (!c.queue_counter_enable) w[68:67] = 2'h0;
    return w;
  endfunction

  task automatic press(logic [5:0] b);
    @(negedge clk);
    button_inputs = b;
    press_start = 1'b1;
    @(negedge clk);
    press_start = 1'b0;
  endtask

  // detector sampled first, then one word requested and compared whole
  task automatic send(logic d, logic [68:0] e, int n, logic a);
    int w0;
    int k;
    w0 = fm_u.words;
    @(negedge clk);
    detector_low = d;
    first_preamble = 1'b1;
    @(negedge clk);
    first_preamble = 1'b0;
    word_request = 1'b1;
    @(negedge clk);
    word_request = 1'b0;
    k = 0;
    while (fm_u.words == w0 && k < 600) begin
      @(negedge clk);
      k++;
    end
    chk("word done", 69'(1), 69'(fm_u.words != w0));
    chk("code word", e, fm_u.word);
    chk("word length", 69'(n), 69'(fm_u.len));
    chk("counter advance", 69'(a), 69'(fm_u.adv));
  endtask

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    cfg_first = '0;
    cfg_first.serial_number = 32'ha5c31e97;
    cfg_first.discrimination_value = 10'h2b6;
    cfg_first.sync_counter = 20'h00023;
    cfg_first.first_overflow_bit = 1'b1;
    cfg_first.second_overflow_bit = 1'b1;
    cfg_first.seed_value = 60'h9abcdef01234567;
    cfg_second = '0;
    cfg_second.serial_number = 32'h7e01b44c;
    cfg_second.discrimination_value = 10'h0d9;
    cfg_second.sync_counter = 20'ha1b2c;
    cfg_second.extended_serial_enable = 1'b1;
    cfg_second.queue_counter_enable = 1'b1;
    dev_opts = '0;
    config_select = 1'b0;
    button_inputs = 6'h00;
    press_start = 1'b0;
    word_request = 1'b0;
    first_preamble = 1'b0;
    words_sent = 4'h0;
    detector_low = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    // every button alone, 16 bit counter, short serial
    for (int b = 0; b < 6; b++) begin
      press(6'h01 << b);
      send(b[0], exp_word(6'h01 << b, b[0], 2'h0, 1'b0), 67,
           1'b1);
    end
    // no new press: hopping part held, cipher not run again
    c0 = fm_u.crypts;
    send(1'b0, exp_word(6'h20, 1'b0, 2'h0, 1'b0), 67, 1'b1);
    chk("cipher runs", 69'(c0), 69'(fm_u.crypts));
    chk("stretch idle", 69'(0), 69'(preamble_stretch));
    // second set, 20 bit counter, long serial, queue bits counted
    config_select = 1'b1;
    dev_opts = 3'b101;
    for (int i = 0; i < 5; i++) begin
      press(6'h09);
      send(i == 0, exp_word(6'h09, i == 0, (i > 3) ? 2'h3 : 2'(i), 1'b0),
           69, 1'b1);
    end
    chk("trip select", 69'(1), 69'(detector_trip_high));
    press(6'h01);
    send(1'b0, exp_word(6'h01, 1'b0, 2'h0, 1'b0), 69, 1'b1);
    // seed words on the first set
    config_select = 1'b0;
    cfg_first.seed_button_field = 4'b1010;
    press(6'h0a);
    send(1'b0, exp_word(6'h0a, 1'b0, 2'h0, 1'b1), 67, 1'b0);
    chk("seed flag", 69'(1), 69'(counter_word_seed));
    cfg_first.seed_production_mode = 1'b1;
    cfg_first.sync_counter = 20'h00010;
    press(6'h0a);
    send(1'b0, exp_word(6'h0a, 1'b0, 2'h0, 1'b0), 67, 1'b1);
    words_sent = 4'h1;
    send(1'b0, exp_word(6'h0a, 1'b0, 2'h0, 1'b1), 67, 1'b1);
    words_sent = 4'h0;
    cfg_first.seed_production_mode = 1'b0;
    cfg_first.limited_seed_enable = 1'b1;
    cfg_first.sync_counter = 20'h00080;
    press(6'h0a);
    send(1'b0, exp_word(6'h0a, 1'b0, 2'h0, 1'b0), 67, 1'b1);
    // counter rolled over to zero: seeds stay off
    cfg_first.sync_counter = 20'h00000;
    press(6'h0a);
    send(1'b0, exp_word(6'h0a, 1'b0, 2'h0, 1'b0), 67, 1'b1);
    cfg_first.limited_seed_enable = 1'b0;
    cfg_first.seed_button_field = 4'b0000;
    press(6'h0a);
    send(1'b0, exp_word(6'h0a, 1'b0, 2'h0, 1'b0), 67, 1'b1);
    // latch keeps the low flag once the supply was seen low
    dev_opts = 3'b011;
    press(6'h04);
    send(1'b1, exp_word(6'h04, 1'b1, 2'h0, 1'b0), 67, 1'b1);
    chk("stretch", 69'(1), 69'(preamble_stretch));
    send(1'b0, exp_word(6'h04, 1'b1, 2'h0, 1'b0), 67, 1'b1);
    chk("latched", 69'(1), 69'(detector_latched));
    test_done();
  end
endmodule

// ==== testbench/hcw_far_model.sv ====
// Purpose: far side model, cipher responder and serial word receiver
// Assumes: tx_valid frames one word, one bit per clock, tx_last on the end
// Notes:   cipher answer is plain xor a key mask, so the key choice shows
`timescale 1ns/1ps

module hcw_far_model #(
  parameter logic [31:0] KEY_A = 32'h3c5a96e1,
  parameter logic [31:0] KEY_B = 32'h0f1e2d3c
) (
  // clock
  input  wire logic        clk,
  // cipher side
  input  wire logic        crypt_start,
  input  wire logic [31:0] crypt_plain,
  input  wire logic        crypt_first_key,
  output logic             crypt_done,
  output logic [31:0]      crypt_result,
  // serial side
  input  wire logic        tx_data,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  input  wire logic        counter_advance
);
  logic [68:0] word     = '0;
  int          len      = 0;
  int          idx      = 0;
  int          words    = 0;
  int          crypts   = 0;
  int          wait_cnt = 0;
  logic        last_q   = 1'b0;
  logic        adv      = 1'b0;

  // slow cipher; result scrambles outside done so stale data never matches
  initial begin
    crypt_done   = 1'b0;
    crypt_result = 32'h0;
  end
  always @(posedge clk) begin
    crypt_done   <= 1'b0;
    crypt_result <= ~crypt_result;
    if (crypt_start && !crypt_done) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == 3) begin
        crypt_done   <= 1'b1;
        crypt_result <= crypt_plain ^ (crypt_first_key ? KEY_A : KEY_B);
        wait_cnt     <= 0;
        crypts       <= crypts + 1;
      end
    end
  end

  // collect bits lsb first; counter update looked at one cycle after end
  always @(posedge clk) begin
    last_q <= tx_valid && tx_last;
    if (tx_valid) begin
      word <= (idx == 0) ? 69'(tx_data) : word | (69'(tx_data) << idx);
      idx  <= tx_last ? 0 : idx + 1;
      if (tx_last) len <= idx + 1;
    end
    if (last_q) begin
      adv   <= counter_advance;
      words <= words + 1;
    end
  end
endmodule
